// [hdl/ddr_timing_defines.svh]
// Purpose: Timing counts, command codes and write strobe steps
// Assumes: clk at 50 MHz, memory clock is clk divided by four
// Notes:   Times keep their printed unit; cycle counts derive from them
`ifndef DDR_TIMING_DEFINES_SVH
`define DDR_TIMING_DEFINES_SVH

`define CLK_NS 20
`define CK_DIV 4
`define CK_NS (`CLK_NS * `CK_DIV)
`define CEIL_DIV(a, b) (((a) + (b) - 1) / (b))

// Least times, rounded up to memory clocks
`define MRD_CK 2
`define XSRD_CK 200
`define XSNR_NS 75
`define XSNR_CK `CEIL_DIV(`XSNR_NS, `CK_NS)
`define RFC_NS 75
`define RFC_CK `CEIL_DIV(`RFC_NS, `CK_NS)
`define WR_NS 15
`define RP_NS 20
`define DAL_CK (`CEIL_DIV(`WR_NS, `CK_NS) + `CEIL_DIV(`RP_NS, `CK_NS))
`define WR_BURST_CK 2

// Longest time, rounded down: 7.8 us average refresh interval
`define REFI_NS 7800
`define REFI_CK (`REFI_NS / `CK_NS)
`define REF_POST_MAX 8

// Command pins {cs_b, ras_b, cas_b, we_b}
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
`define CMD_NOP 4'h7

// Write steps in clk cycles, step 0 drives the write command
`define WSTEP_DQ 4'h5
`define WSTEP_RISE 4'h6
`define WSTEP_BYTE1 4'h7
`define WSTEP_FALL 4'h8
`define WSTEP_END 4'hA

`endif

// [hdl/ddr_timing_pkg.sv]
// Purpose: Types shared by the memory timing controller
// Assumes: Nothing
// Notes:   Command pin struct packs in pin order
package ddr_timing_pkg;

    typedef enum logic [3:0] {
        OP_NOP, OP_MRS, OP_ACT, OP_READ, OP_WRITE, OP_WRITE_AP, OP_PRE,
        OP_SREF_ENTER, OP_SREF_EXIT, OP_INIT
    } op_e;

    typedef enum logic [1:0] {ST_HALT, ST_IDLE, ST_SREF} ctrl_state_e;

    typedef struct packed {
        op_e op;
        logic [1:0] bank;
        logic [12:0] addr;
    } user_cmd_s;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
    } ddr_cmd_s;

endpackage

// [hdl/pair_buffer.sv]
// Purpose: Small FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   in_ready is registered
`timescale 1ns/10ps
module pair_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic in_valid, // Word offered
    input wire logic [WIDTH-1:0] in_data, // Offered word
    output logic in_ready, // Room for a word
    output logic out_valid, // Word available
    output logic [WIDTH-1:0] out_data, // Oldest word
    input wire logic out_ready // Drain takes the word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic in_ready_q;
    wire logic push = in_valid && in_ready_q;
    wire logic pop = out_valid && out_ready;

    assign in_ready = in_ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b0;
        end else begin
            wp_q <= push ? wp_q + AW'(1) : wp_q;
            rp_q <= pop ? rp_q + AW'(1) : rp_q;
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule // pair_buffer

// [hdl/ddr_timing_ctrl.sv]
// Purpose: Host side command and strobe timing for a DDR memory
// Assumes: Memory clock is clk / 4; burst length two, one x8 lane
// Notes:   Commands change on the falling memory clock edge
`timescale 1ns/10ps
`include "ddr_timing_defines.svh"

module ddr_timing_ctrl
    import ddr_timing_pkg::*;
(
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic cmd_valid, // User command offered
    input wire user_cmd_s cmd, // User command
    output logic cmd_ack, // Command taken, one cycle
    input wire logic wr_valid, // Write word offered
    input wire logic [15:0] wr_data, // Write word, low byte first
    output logic wr_ready, // Write buffer has room
    output logic rd_valid, // Read word, one cycle
    output logic [15:0] rd_data, // Read word, low byte first
    output logic ddr_ck, // Memory clock
    output logic ddr_ck_b, // Memory clock, inverted
    output logic ddr_cke, // Memory clock enable
    output ddr_cmd_s ddr_cmd, // Command pins
    output logic [1:0] ddr_ba, // Bank address
    output logic [12:0] ddr_addr, // Address
    input wire logic dqs_i, // Strobe pin level
    output logic dqs_o, // Strobe drive value
    output logic dqs_oe_b, // Strobe driven while low
    input wire logic [7:0] dq_i, // Data pin levels
    output logic [7:0] dq_o, // Data drive value
    output logic dq_oe_b, // Data driven while low
    output logic clk_change_ok, // Memory clock may change
    output logic init_needed // Waiting for an init command
);
    logic [1:0] phase_q;
    logic ck_q, ck_b_q, cke_q, cmd_new_q, ack_q;
    ctrl_state_e state_q;
    ddr_cmd_s cmd_q;
    logic [1:0] ba_q;
    logic [12:0] addr_q;
    logic [1:0] mrd_cnt_q, gap_cnt_q, xsnr_cnt_q;
    logic [2:0] dal_cnt_q;
    logic [7:0] xsrd_cnt_q, since_exit_q;
    logic [6:0] refi_cnt_q;
    logic [3:0] ref_pend_q, wstep_q;
    logic wr_busy_q, dqs_q, dqs_oe_b_q, dq_oe_b_q;
    logic [7:0] dq_q, rd_lo_q;
    logic dqs_s1, dqs_s2, dqs_s3, rd_win_q, rd_seen_q, rd_valid_q;
    logic [7:0] dq_s1, dq_s2;
    logic [15:0] rd_data_q;
    logic chg_ok_q, init_q;
    logic buf_valid;
    logic [15:0] buf_data;

    wire logic [1:0] phase_d = phase_q + 2'h1;
    wire logic tick = (phase_q == 2'h1);
    wire logic in_idle = (state_q == ST_IDLE);
    wire logic is_read = (cmd.op == OP_READ);
    wire logic is_wr = (cmd.op == OP_WRITE) || (cmd.op == OP_WRITE_AP);
    wire logic legal_idle = cmd.op inside {OP_NOP, OP_MRS, OP_ACT, OP_READ,
        OP_WRITE, OP_WRITE_AP, OP_PRE, OP_SREF_ENTER};
    wire logic blk_any = (mrd_cnt_q != 2'h0) || (gap_cnt_q != 2'h0) ||
        (dal_cnt_q != 3'h0) || wr_busy_q;
    wire logic xs_ok = is_read ? (xsrd_cnt_q == 8'h00)
                               : (xsnr_cnt_q == 2'h0);
    wire logic ref_full = (ref_pend_q == 4'(`REF_POST_MAX));
    wire logic do_ref = tick && in_idle && (ref_pend_q != 4'h0) &&
        !blk_any && (xsnr_cnt_q == 2'h0) &&
        (ref_full || !cmd_valid);
    wire logic take_idle = tick && in_idle && cmd_valid && legal_idle &&
        !ref_full && !blk_any && xs_ok && (!is_wr || buf_valid);
    wire logic take_wr = take_idle && is_wr;
    wire logic take_rd = take_idle && is_read;
    wire logic take_exit = tick && (state_q == ST_SREF) && cmd_valid &&
        (cmd.op == OP_SREF_EXIT);
    wire logic take_init = tick && (state_q == ST_HALT) && cmd_valid &&
        (cmd.op == OP_INIT);
    wire logic illegal = tick && cmd_valid &&
        ((in_idle && !legal_idle) ||
         ((state_q == ST_SREF) && (cmd.op != OP_SREF_EXIT)));
    wire logic sref_in = take_idle && (cmd.op == OP_SREF_ENTER);

    wire logic [3:0] op_code =
        do_ref ? `CMD_REF :
        !take_idle ? `CMD_NOP :
        (cmd.op == OP_MRS) ? `CMD_MRS :
        (cmd.op == OP_ACT) ? `CMD_ACT :
        is_read ? `CMD_RD :
        is_wr ? `CMD_WR :
        (cmd.op == OP_PRE) ? `CMD_PRE :
        sref_in ? `CMD_REF : `CMD_NOP;
    wire logic cke_d = (take_exit || take_init) ? 1'b1 :
        (illegal || sref_in) ? 1'b0 : cke_q;
    wire ctrl_state_e state_d = illegal ? ST_HALT :
        take_init ? ST_IDLE :
        take_exit ? ST_IDLE :
        sref_in ? ST_SREF : state_q;

    // Write strobe sequence, stepped in clk cycles from the command
    wire logic [3:0] nstep = take_wr ? 4'h0 : wstep_q + 4'h1;
    wire logic wr_busy_d = take_wr || (wr_busy_q && (nstep != `WSTEP_END));
    wire logic dqs_d = wr_busy_d && (nstep >= `WSTEP_RISE) &&
        (nstep < `WSTEP_FALL);
    wire logic dq_oe_b_d = !(wr_busy_d && (nstep >= `WSTEP_DQ));
    wire logic [7:0] dq_d = (nstep > `WSTEP_FALL) ? dq_q :
        (nstep < `WSTEP_BYTE1) ? buf_data[7:0] : buf_data[15:8];
    wire logic buf_pop = wr_busy_q && (wstep_q == `WSTEP_FALL);

    // Read strobe edges seen after synchronisation
    wire logic dqs_rise = dqs_s2 && !dqs_s3;
    wire logic dqs_fall = !dqs_s2 && dqs_s3;
    // A fall counts only after the first rise: an idle high strobe
    // falling into its preamble must not end the burst early
    wire logic rd_first = rd_win_q && !rd_seen_q && dqs_rise;
    wire logic rd_done = rd_win_q && rd_seen_q && dqs_fall;

    pair_buffer #(.WIDTH(16), .DEPTH(2)) u_wbuf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(wr_valid),
        .in_data(wr_data),
        .in_ready(wr_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_pop)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= 2'h0;
            ck_q <= 1'b0;
            ck_b_q <= 1'b1;
        end else begin
            phase_q <= phase_d;
            ck_q <= (phase_d < 2'h2);
            ck_b_q <= !(phase_d < 2'h2);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_HALT;
            cke_q <= 1'b0;
            cmd_q <= ddr_cmd_s'(`CMD_NOP);
            ba_q <= 2'h0;
            addr_q <= 13'h0000;
        end else if (tick) begin
            state_q <= state_d;
            cke_q <= cke_d;
            cmd_q <= ddr_cmd_s'(op_code);
            ba_q <= take_idle ? cmd.bank : ba_q;
            addr_q <= take_idle ? cmd.addr : addr_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_new_q <= 1'b0;
            ack_q <= 1'b0;
            chg_ok_q <= 1'b0;
            init_q <= 1'b1;
        end else begin
            cmd_new_q <= tick && (op_code != `CMD_NOP);
            ack_q <= take_idle || take_exit || take_init || illegal;
            chg_ok_q <= (state_d == ST_SREF);
            init_q <= (state_d == ST_HALT);
        end
    end

    // Down-counters, one per limit, stepped once per memory clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mrd_cnt_q <= 2'h0;
            gap_cnt_q <= 2'h0;
            dal_cnt_q <= 3'h0;
        end else if (tick) begin
            mrd_cnt_q <= (take_idle && (cmd.op == OP_MRS)) ?
                2'(`MRD_CK - 1) : mrd_cnt_q - 2'(mrd_cnt_q != 2'h0);
            gap_cnt_q <= do_ref ? 2'(`RFC_CK - 1) :
                gap_cnt_q - 2'(gap_cnt_q != 2'h0);
            dal_cnt_q <= (take_idle && (cmd.op == OP_WRITE_AP)) ?
                3'(`WR_BURST_CK + `DAL_CK - 1) :
                dal_cnt_q - 3'(dal_cnt_q != 3'h0);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xsrd_cnt_q <= 8'h00;
            xsnr_cnt_q <= 2'h0;
        end else if (take_exit) begin
            xsrd_cnt_q <= 8'(`XSRD_CK - 1);
            xsnr_cnt_q <= 2'(`XSNR_CK - 1);
        end else if (tick) begin
            xsrd_cnt_q <= xsrd_cnt_q - 8'(xsrd_cnt_q != 8'h00);
            xsnr_cnt_q <= xsnr_cnt_q - 2'(xsnr_cnt_q != 2'h0);
        end
    end

    // Refresh interval and postponed count; a full count blocks users
    wire logic refi_end = tick && in_idle && (refi_cnt_q == 7'h00);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refi_cnt_q <= 7'(`REFI_CK - 1);
            ref_pend_q <= 4'h0;
        end else begin
            if (tick && in_idle) begin
                refi_cnt_q <= refi_end ? 7'(`REFI_CK - 1) : refi_cnt_q - 7'h01;
            end
            ref_pend_q <= ref_pend_q + 4'(refi_end && !ref_full) -
                4'(do_ref);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_busy_q <= 1'b0;
            wstep_q <= 4'h0;
            dqs_q <= 1'b0;
            dqs_oe_b_q <= 1'b1;
            dq_q <= 8'h00;
            dq_oe_b_q <= 1'b1;
        end else begin
            wr_busy_q <= wr_busy_d;
            wstep_q <= wr_busy_d ? nstep : 4'h0;
            dqs_q <= dqs_d;
            dqs_oe_b_q <= !wr_busy_d;
            dq_q <= dq_d;
            dq_oe_b_q <= dq_oe_b_d;
        end
    end

    // Read capture relies on the low preamble before the first rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dqs_s1 <= 1'b0;
            dqs_s2 <= 1'b0;
            dqs_s3 <= 1'b0;
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dqs_s1 <= dqs_i;
            dqs_s2 <= dqs_s1;
            dqs_s3 <= dqs_s2;
            dq_s1 <= dq_i;
            dq_s2 <= dq_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_win_q <= 1'b0;
            rd_seen_q <= 1'b0;
            rd_lo_q <= 8'h00;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_win_q <= take_rd || (rd_win_q && !rd_done);
            rd_seen_q <= rd_win_q && !take_rd && !rd_done &&
                (rd_seen_q || dqs_rise);
            rd_lo_q <= rd_first ? dq_s2 : rd_lo_q;
            rd_valid_q <= rd_done;
            rd_data_q <= rd_done ? {dq_s2, rd_lo_q} : rd_data_q;
        end
    end

    // Helper for checks: memory clocks since self refresh exit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_exit_q <= 8'hFF;
        end else if (take_exit) begin
            since_exit_q <= 8'h00;
        end else if (tick && (since_exit_q != 8'hFF)) begin
            since_exit_q <= since_exit_q + 8'h01;
        end
    end

    assign cmd_ack = ack_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign ddr_ck = ck_q;
    assign ddr_ck_b = ck_b_q;
    assign ddr_cke = cke_q;
    assign ddr_cmd = cmd_q;
    assign ddr_ba = ba_q;
    assign ddr_addr = addr_q;
    assign dqs_o = dqs_q;
    assign dqs_oe_b = dqs_oe_b_q;
    assign dq_o = dq_q;
    assign dq_oe_b = dq_oe_b_q;
    assign clk_change_ok = chg_ok_q;
    assign init_needed = init_q;

    mode_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_new_q && (cmd_q == ddr_cmd_s'(`CMD_MRS)) |->
            ##4 (cmd_q == ddr_cmd_s'(`CMD_NOP)))
        else $error("command too soon after mode set");
    exit_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        take_rd |-> (since_exit_q >= 8'(`XSRD_CK - 1)))
        else $error("read too soon after self refresh exit");
    exit_other_a: assert property (@(posedge clk) disable iff (!rst_b)
        tick && (xsnr_cnt_q != 2'h0) |-> !do_ref && !(take_idle && !is_read))
        else $error("command too soon after self refresh exit");
    refresh_post_a: assert property (@(posedge clk) disable iff (!rst_b)
        ref_full |-> !take_idle)
        else $error("user command taken with refreshes fully postponed");
    strobe_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_new_q && (cmd_q == ddr_cmd_s'(`CMD_WR)) |-> !dqs_oe_b_q && !dqs_q)
        else $error("write strobe not driven low at write command");
    first_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_new_q && (cmd_q == ddr_cmd_s'(`CMD_WR)) |->
            (!dqs_q && !dqs_oe_b_q)[*6] ##1 dqs_q)
        else $error("first write strobe rise misplaced");
    strobe_width_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(dqs_q) |-> dqs_q ##1 dqs_q ##1 !dqs_q ##1 !dqs_q)
        else $error("write strobe phase too short");
    postamble_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(dqs_q) |-> (!dqs_oe_b_q)[*2] ##1 dqs_oe_b_q)
        else $error("write strobe postamble wrong");
    halt_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(init_q) |-> ##[0:4] !cke_q)
        else $error("memory not powered down after illegal operation");
    clk_change_a: assert property (@(posedge clk) disable iff (!rst_b)
        chg_ok_q |-> !cke_q && (state_q == ST_SREF))
        else $error("clock change allowed outside self refresh");
endmodule // ddr_timing_ctrl

// [tb/ddr_mem_model.sv]
// Purpose: Behavioural memory beside the timing controller
// Assumes: Read data starts READ_LAT memory clocks after the command
// Notes:   Counts controller timing faults in viol
`timescale 1ns/10ps
`include "ddr_timing_defines.svh"
module ddr_mem_model
    import ddr_timing_pkg::*;
#(
    parameter int READ_LAT = 2,
    parameter real CKP = 80.0
) (
    input wire logic ck, // Memory clock
    input wire logic cke, // Clock enable
    input wire ddr_cmd_s cmd, // Command pins
    input wire logic ctl_s, // Controller drives strobe
    input wire logic ctl_d, // Controller drives data
    input wire logic dqs_pin, // Strobe wire
    input wire logic [7:0] dq_pin, // Data wire
    output logic dqs_out, // Strobe offered
    output logic [7:0] dq_out, // Data offered
    output int viol, // Controller faults seen
    output int ref_cnt, // Refreshes seen
    output logic [15:0] word // Last word written
);
    logic own_s = 1'b0;
    logic own_d = 1'b0;
    logic s_v = 1'b0;
    logic [7:0] d_v = 8'h00;
    logic last_s = 1'b1;
    logic [7:0] last_d = 8'h00;
    logic cke_q = 1'b0;
    logic in_sref = 1'b0;
    int ck_n = 0;
    int mrs_n = -10;
    int exit_n = -1000;
    realtime exit_t = -1000.0;

    // Released wires show the inverse of their last driven level
    assign dqs_out = own_s ? s_v : ~last_s;
    assign dq_out = own_d ? d_v : ~last_d;
    initial begin
        viol = 0;
        ref_cnt = 0;
        word = 16'h0000;
    end
    always @(dqs_pin or dq_pin) begin
        if (ctl_s || own_s) last_s = dqs_pin;
        if (ctl_d || own_d) last_d = dq_pin;
    end
    task automatic fault();
        viol = viol + 1;
    endtask
    task automatic read_burst();
        repeat (READ_LAT - 1) @(posedge ck);
        #0.5;
        s_v = 1'b0;
        own_s = 1'b1;
        @(posedge ck);
        #0.5;
        s_v = 1'b1;
        d_v = word[7:0];
        own_d = 1'b1;
        #(CKP / 2.0);
        s_v = 1'b0;
        d_v = word[15:8];
        #(CKP / 2.0);
        own_s = 1'b0;
        own_d = 1'b0;
    endtask
    task automatic write_check();
        realtime tc, tr, tf, d;
        int k;
        tc = $realtime;
        if (!ctl_s || dqs_pin !== 1'b0) fault();
        @(posedge dqs_pin);
        tr = $realtime;
        word[7:0] = dq_pin;
        d = (tr - tc) / CKP;
        if (d < 0.75 || d > 1.25) fault();
        @(negedge dqs_pin);
        tf = $realtime;
        word[15:8] = dq_pin;
        if (tf - tr < 0.35 * CKP) fault();
        k = $rtoi((tf - tc) / CKP + 0.5);
        d = tf - tc - k * CKP;
        if (d < 0.2 * CKP && d > -0.2 * CKP) fault();
        wait (!ctl_s);
        if ($realtime - tf < 0.4 * CKP) fault();
    endtask
    always @(posedge ck) begin
        ck_n = ck_n + 1;
        if (cke && !cke_q && in_sref) begin
            in_sref = 1'b0;
            exit_n = ck_n;
            exit_t = $realtime;
        end
        cke_q = cke;
        if (cmd.cs_b == 1'b0 && cmd != `CMD_NOP) begin
            if (ck_n - mrs_n < `MRD_CK) fault();
            if (cmd == `CMD_RD && ck_n - exit_n < `XSRD_CK) fault();
            if (cmd != `CMD_RD && $realtime - exit_t < `XSNR_NS) fault();
            if (cmd == `CMD_MRS) mrs_n = ck_n;
            if (cmd == `CMD_REF && cke) ref_cnt = ref_cnt + 1;
            if (cmd == `CMD_REF && !cke) in_sref = 1'b1;
            if (cmd == `CMD_RD) fork read_burst(); join_none
            if (cmd == `CMD_WR) fork write_check(); join_none
        end
    end
endmodule // ddr_mem_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the memory timing controller
// Assumes: Memory model sits on the controller's pins
// Notes:   Gaps are measured in ns between acknowledge edges
`timescale 1ns/10ps
`include "ddr_timing_defines.svh"
module tb_top
    import ddr_timing_pkg::*;
();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    user_cmd_s cmd = '{OP_NOP, 2'h1, 13'h0123};
    logic wr_valid = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic cmd_ack, wr_ready, rd_valid, ddr_ck, ddr_ck_b, ddr_cke;
    logic [15:0] rd_data, word;
    ddr_cmd_s ddr_cmd;
    logic [1:0] ddr_ba;
    logic [12:0] ddr_addr;
    logic dqs_o, dqs_oe_b, dq_oe_b, clk_change_ok, init_needed, mem_s;
    logic [7:0] dq_o, mem_d;
    wire logic dqs_pin;
    wire logic [7:0] dq_pin;
    int viol, ref_cnt;
    int miscompares = 0;
    int checks = 0;
    time ta, tz;
    logic ok;

    always #10 clk = ~clk;
    assign dqs_pin = !dqs_oe_b ? dqs_o : mem_s;
    assign dq_pin = !dq_oe_b ? dq_o : mem_d;

    ddr_timing_ctrl DUT (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ack(cmd_ack), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .ddr_ck(ddr_ck), .ddr_ck_b(ddr_ck_b),
        .ddr_cke(ddr_cke), .ddr_cmd(ddr_cmd), .ddr_ba(ddr_ba),
        .ddr_addr(ddr_addr), .dqs_i(dqs_pin), .dqs_o(dqs_o),
        .dqs_oe_b(dqs_oe_b), .dq_i(dq_pin), .dq_o(dq_o),
        .dq_oe_b(dq_oe_b), .clk_change_ok(clk_change_ok),
        .init_needed(init_needed));
    ddr_mem_model mem (.ck(ddr_ck), .cke(ddr_cke), .cmd(ddr_cmd),
        .ctl_s(!dqs_oe_b), .ctl_d(!dq_oe_b), .dqs_pin(dqs_pin),
        .dq_pin(dq_pin), .dqs_out(mem_s), .dq_out(mem_d), .viol(viol),
        .ref_cnt(ref_cnt), .word(word));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic issue(input op_e op, input int lim, output logic a,
                         output time t);
        int n;
        n = 0;
        a = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd.op <= op;
        while (!a && n < lim) begin
            @(posedge clk);
            n++;
            a = (cmd_ack === 1'b1);
        end
        t = $time;
        cmd_valid <= 1'b0;
    endtask
    task automatic run(input op_e op, output time t);
        logic a;
        issue(op, 3000, a, t);
        check(16'(a), 16'h0001);
    endtask
    task automatic push(input logic [15:0] w, output int n);
        n = 0;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wr_ready !== 1'b1 && n < 3000);
        wr_valid <= 1'b0;
    endtask
    task automatic get_read(input logic [15:0] exp);
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check(16'(n < 300), 16'h0001);
        check(rd_data, exp);
    endtask
    task automatic s_init();
        issue(OP_READ, 40, ok, ta);
        check(16'(ok), 16'h0000);
        run(OP_INIT, ta);
        @(negedge clk);
        check(16'({ddr_cke, init_needed}), 16'h0002);
        run(OP_PRE, ta);
        run(OP_NOP, ta);
        run(OP_MRS, ta);
        check(16'(ddr_addr), 16'h0123);
        run(OP_PRE, tz);
        check(16'(tz - ta >= `MRD_CK * `CK_NS), 16'h0001);
    endtask
    task automatic s_fill();
        int w0, w1, w2;
        push(16'hA1B2, w0);
        push(16'hC3D4, w1);
        check(16'(w0 + w1), 16'h0002);
        fork
            begin
                push(16'hE5F6, w2);
                check(16'(w2 >= 30), 16'h0001);
            end
            begin
                repeat (30) @(posedge clk);
                run(OP_ACT, ta);
                run(OP_WRITE, ta);
            end
        join
        repeat (12) @(posedge clk);
        check(word, 16'hA1B2);
        run(OP_WRITE, ta);
        repeat (12) @(posedge clk);
        check(word, 16'hC3D4);
        run(OP_WRITE_AP, ta);
        run(OP_ACT, tz);
        check(16'(tz - ta >= 4 * `CK_NS), 16'h0001);
        check(word, 16'hE5F6);
        run(OP_READ, ta);
        get_read(16'hE5F6);
    endtask
    task automatic s_sref();
        run(OP_SREF_ENTER, ta);
        @(negedge clk);
        check(16'({clk_change_ok, ddr_cke}), 16'h0002);
        run(OP_SREF_EXIT, ta);
        @(negedge clk);
        check(16'(clk_change_ok), 16'h0000);
        run(OP_READ, tz);
        check(16'(tz - ta >= `XSRD_CK * `CK_NS), 16'h0001);
        get_read(16'hE5F6);
        run(OP_SREF_ENTER, ta);
        run(OP_SREF_EXIT, ta);
        run(OP_PRE, tz);
        check(16'(tz - ta >= `XSNR_NS), 16'h0001);
    endtask
    task automatic s_refresh();
        int r0;
        repeat (400) @(posedge clk);
        r0 = ref_cnt;
        // 300 memory clocks hold three or four 97-clock intervals
        repeat (1200) @(posedge clk);
        check(16'(ref_cnt - r0 inside {3, 4}), 16'h0001);
    endtask
    task automatic s_illegal();
        run(OP_SREF_EXIT, ta);
        @(negedge clk);
        check(16'({ddr_cke, init_needed}), 16'h0001);
        issue(OP_PRE, 40, ok, ta);
        check(16'(ok), 16'h0000);
        run(OP_INIT, ta);
        @(negedge clk);
        check(16'(init_needed), 16'h0000);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        s_init();
        s_fill();
        s_sref();
        s_refresh();
        s_illegal();
        check(16'(viol), 16'h0000);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule // tb_top
